// ===== core/tmd_decoder.sv
// terminal microinstruction decoder: rom fetch, timed strobes, branch and constant load
`timescale 1ns/1ps
`default_nettype none
module tmd_decoder #(
    parameter int unsigned CYCLE_CYC = tmd_pkg::CYCLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] rom_data,
    output logic [9:0] rom_addr,
    input wire logic [15:0] flags_n,
    input wire logic [7:0] ram_rdata,
    input wire logic [7:0] rx_data,
    input wire logic [5:0] column_val,
    input wire logic control_key,
    output logic [7:0] te_strobe_n,
    output logic [7:0] tf_strobe_n,
    output logic [7:0] th_strobe_n,
    output logic [7:0] alt_strobe_n,
    output logic ram_we,
    output logic [7:0] ram_wdata,
    output logic [7:0] working_value_register,
    output logic select_flag_q,
    output logic done_flag_q,
    output logic [1:0] timing_slot,
    output logic slot_pulse
);
    initial begin
        if (CYCLE_CYC < 2 * tmd_pkg::NSLOT * tmd_pkg::SLOT_CYC) begin
            $error("tmd_decoder: CYCLE_CYC too short for six slots");
        end
    end

    // rom data, flags and the control key pass two flops before use; ram_rdata and rx_data are used directly
    logic [7:0] rom_s1_q, rom_s2_q;
    logic [15:0] flg_s1_q, flg_s2_q;
    logic ctl_s1_q, ctl_s2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_s1_q <= 8'h00;
            rom_s2_q <= 8'h00;
        end else begin
            rom_s1_q <= rom_data;
            rom_s2_q <= rom_s1_q;
        end
    end

    // flags idle high, so a quiet pin reads as no flag after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flg_s1_q <= 16'hFFFF;
            flg_s2_q <= 16'hFFFF;
        end else begin
            flg_s1_q <= flags_n;
            flg_s2_q <= flg_s1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_s1_q <= 1'b0;
            ctl_s2_q <= 1'b0;
        end else begin
            ctl_s1_q <= control_key;
            ctl_s2_q <= ctl_s1_q;
        end
    end

    // timing: one counter per instruction cycle, slots spaced along it
    logic [10:0] cyc_q;
    logic run_q;
    wire cyc_end = (cyc_q == 11'(CYCLE_CYC - 1));
    wire [10:0] slot_pos = cyc_q;
    function automatic logic at_slot(input logic [10:0] pos, input int unsigned s);
        at_slot = (pos == 11'(s * tmd_pkg::SLOT_CYC * 2 + tmd_pkg::SLOT_CYC));
    endfunction
    // each pulse lasts one edge here; the strobes below are registered copies and also last one clock
    wire p_te = run_q && at_slot(slot_pos, 0);
    wire p_tf = run_q && at_slot(slot_pos, 1);
    wire p_tw = run_q && at_slot(slot_pos, 2);
    wire p_tg = run_q && at_slot(slot_pos, 3);
    wire p_th = run_q && at_slot(slot_pos, 4);
    wire p_tj = run_q && at_slot(slot_pos, 5);
    // the word is latched early in the cycle, after the synchroniser settles
    wire p_fetch = run_q && (cyc_q == 11'd3);

    // instruction register and field decode
    logic [7:0] ir_q;
    logic jump_word_q;
    logic [9:0] pc_q;
    logic [1:0] page_next_q;
    logic select_q, done_q, test_pass_q;
    logic [7:0] work_q;
    wire bit_a = ir_q[tmd_pkg::BIT_A];
    wire [2:0] sub = ir_q[6:4];
    wire bit_e = ir_q[tmd_pkg::BIT_E];
    wire bit_f = ir_q[tmd_pkg::BIT_F];
    wire bit_g = ir_q[tmd_pkg::BIT_G];
    wire bit_h = ir_q[tmd_pkg::BIT_H];
    wire is_exec = !jump_word_q;
    wire ops_zero = !(bit_e | bit_f | bit_g | bit_h);
    wire en_te = is_exec && !bit_a && bit_e;
    wire en_tf = is_exec && !bit_a && bit_f;
    wire en_tg = is_exec && !bit_a && bit_g;
    wire en_alt = is_exec && !bit_a && ops_zero;
    wire is_test = is_exec && !bit_a && bit_h;

    function automatic logic [7:0] one_low(input logic en, input logic [2:0] sel);
        one_low = en ? ~(8'h01 << sel) : 8'hFF;
    endfunction

    // ram write source decode, enabled for the whole instruction
    wire w_work = en_tg && (sub == tmd_pkg::SUB_1);
    wire w_space = en_tg && (sub == tmd_pkg::SUB_3);
    wire w_rx = en_tg && (sub == tmd_pkg::SUB_5);
    wire cl_mode = is_exec && bit_a;
    wire [7:0] work_plus = work_q + 8'h01;
    // compared at TW and TG, after the TF increment has already landed
    wire not_less = !(work_q < ram_rdata);
    // with select set, store only on the first not-less word of a run; with select clear, store every word
    wire cl_store = cl_mode && (!select_q || (not_less && !done_q));
    wire [7:0] cl_const = {1'b0, ir_q[6:0]};
    wire [7:0] cl_data = (select_q && ctl_s2_q) ? (cl_const & tmd_pkg::CTRL_MASK) : cl_const;
    wire [1:0] src_sel = cl_store ? tmd_pkg::SRC_CONST : w_rx ? tmd_pkg::SRC_RX :
                         w_space ? tmd_pkg::SRC_SPACE : tmd_pkg::SRC_WORK;
    wire ram_write = w_work | w_space | w_rx | cl_store;
    wire [7:0] mux_data = (src_sel == tmd_pkg::SRC_CONST) ? cl_data :
                          (src_sel == tmd_pkg::SRC_RX) ? rx_data :
                          (src_sel == tmd_pkg::SRC_SPACE) ? tmd_pkg::SPACE_CONST : work_q;

    // flag select: mode picks one of two banks of eight
    wire [3:0] flag_idx = {select_q, sub};
    wire flag_low = !flg_s2_q[flag_idx];
    wire bank_adv = en_tf && (sub == tmd_pkg::SUB_5);
    wire pc_carry = (pc_q[7:0] == 8'hFF);

    // apb: zero-wait slave, four words
    wire apb_wr = psel && penable && pwrite;
    wire apb_rd = psel && !penable && !pwrite;
    wire hit_ctrl = (paddr == tmd_pkg::OFF_CTRL);
    wire hit_stat = (paddr == tmd_pkg::OFF_STATUS);
    wire hit_pc = (paddr == tmd_pkg::OFF_PC);
    wire hit_work = (paddr == tmd_pkg::OFF_WORK);
    wire hit_any = hit_ctrl | hit_stat | hit_pc | hit_work;
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, run_q} :
                         hit_stat ? {26'h0, page_next_q, test_pass_q, done_q, select_q, jump_word_q} :
                         hit_pc ? {22'h0, pc_q} :
                         hit_work ? {24'h0, work_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            if (apb_rd) begin
                prdata <= rd_mux;
            end
        end
    end

    // run comes up set so the microprogram starts without software help
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b1;
        end else if (apb_wr && hit_ctrl) begin
            run_q <= pwdata[tmd_pkg::CTRL_RUN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= 11'h0;
        end else if (!run_q || cyc_end) begin
            cyc_q <= 11'h0;
        end else begin
            cyc_q <= cyc_q + 11'h1;
        end
    end

    // one subset action at one slot
    function automatic logic act(input logic slot, input logic en, input logic [2:0] s,
        input logic [2:0] want);
        act = slot && en && (s == want);
    endfunction

    // action decodes, each but jump_taken a one-clock pulse at its slot; jump_taken is a level
    wire working_clear = act(p_te, en_te, sub, tmd_pkg::SUB_4);
    wire select_flag_set_one = act(p_te, en_te, sub, tmd_pkg::SUB_5);
    wire select_flag_set_zero = act(p_te, en_te, sub, tmd_pkg::SUB_7);
    wire working_increment = act(p_tf, en_tf, sub, tmd_pkg::SUB_1) ||
                             act(p_tf, en_tf, sub, tmd_pkg::SUB_2);
    wire working_decrement = act(p_tf, en_tf, sub, tmd_pkg::SUB_7);
    wire cl_bump = p_tf && cl_mode && select_q;
    // memory into working lands at TH, once the ram output has settled
    wire mem_to_working = act(p_th, en_tg, sub, tmd_pkg::SUB_0);
    wire done_set = p_tg && cl_store && select_q;
    wire done_clear = p_tg && is_exec && !bit_a;
    wire test_sample = p_tg && is_test;
    wire jump_taken = jump_word_q && test_pass_q;
    wire page_carry = p_th && pc_carry && !jump_taken;
    // only the even subsets move memory outward; odd G subsets 1, 3 and 5 write ram instead
    wire th_enable = p_th && en_tg && !sub[0];
    wire [1:0] slot_code = {p_tg | p_th | p_tj, p_tf | p_th};
    wire any_slot = p_te | p_tf | p_tw | p_tg | p_th | p_tj;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_q <= 8'h00;
        end else if (p_fetch) begin
            ir_q <= rom_s2_q;
        end
    end

    // a jump word is never executed, so reset must start on an instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jump_word_q <= 1'b0;
            pc_q <= 10'h000;
        end else if (p_tj) begin
            if (jump_taken) begin
                pc_q <= {page_next_q, ir_q};
                jump_word_q <= 1'b0;
            end else begin
                pc_q <= pc_q + 10'h001;
                jump_word_q <= is_test;
            end
        end
    end

    // pass flag: sampled at TG of the test, dropped after its jump word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_pass_q <= 1'b0;
        end else if (test_sample) begin
            test_pass_q <= (sub == tmd_pkg::SUB_5) || flag_low;
        end else if (p_tj && jump_word_q) begin
            test_pass_q <= 1'b0;
        end
    end

    // advance at TF and bank carry at TH may both land in one instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_next_q <= 2'h0;
        end else if (bank_adv && p_tf) begin
            page_next_q <= page_next_q + 2'h1;
        end else if (page_carry) begin
            page_next_q <= page_next_q + 2'h1;
        end
    end

    // slots are disjoint and the two TF branches need different words, so at most one branch fires per clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_q <= 8'h00;
        end else if (working_clear) begin
            work_q <= 8'h00;
        end else if (working_increment || cl_bump) begin
            work_q <= work_plus;
        end else if (working_decrement) begin
            work_q <= work_q - 8'h01;
        end else if (mem_to_working) begin
            work_q <= ram_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_q <= 1'b0;
        end else if (select_flag_set_one) begin
            select_q <= 1'b1;
        end else if (select_flag_set_zero) begin
            select_q <= 1'b0;
        end
    end

    // set and clear need opposite values of bit A, so they never meet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (done_set) begin
            done_q <= 1'b1;
        end else if (done_clear) begin
            done_q <= 1'b0;
        end
    end

    // registered strobes, so each stands exactly one clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            te_strobe_n <= 8'hFF;
            tf_strobe_n <= 8'hFF;
            th_strobe_n <= 8'hFF;
            alt_strobe_n <= 8'hFF;
        end else begin
            te_strobe_n <= one_low(p_te && en_te, sub);
            tf_strobe_n <= one_low(p_tf && en_tf, sub);
            th_strobe_n <= one_low(th_enable, sub);
            alt_strobe_n <= one_low(p_te && en_alt, sub);
        end
    end

    // write data is frozen for the whole TW..TG window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_we <= 1'b0;
            ram_wdata <= 8'h00;
        end else if (p_tw && ram_write) begin
            ram_we <= 1'b1;
            ram_wdata <= mux_data;
        end else if (p_tg) begin
            ram_we <= 1'b0;
        end
    end

    // status mirrors trail the internal state by one clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_addr <= 10'h000;
            working_value_register <= 8'h00;
            select_flag_q <= 1'b0;
            done_flag_q <= 1'b0;
        end else begin
            rom_addr <= pc_q;
            working_value_register <= work_q;
            select_flag_q <= select_q;
            done_flag_q <= done_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_slot <= 2'h0;
            slot_pulse <= 1'b0;
        end else begin
            timing_slot <= slot_code;
            slot_pulse <= any_slot;
        end
    end
endmodule
`default_nettype wire

// ===== inc/tmd_pkg.sv
// package: constants for the terminal microinstruction decoder
package tmd_pkg;
    localparam int unsigned WORD_W = 8;
    localparam int unsigned PC_W = 10;
    localparam int unsigned PAGE_W = 2;
    localparam int unsigned OFF_W = 8;
    localparam int unsigned CONST_W = 7;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned PULSE_NS = 72;
    localparam int unsigned CYCLE_NS = 1300;
    localparam int unsigned SLOT_CYC = PULSE_NS / CLK_NS;
    localparam int unsigned CYCLE_CYC = CYCLE_NS / CLK_NS;
    localparam int unsigned NSLOT = 6;
    localparam int unsigned SLOT_CNT_W = 8;
    // instruction bit positions, bit A is the msb
    localparam int unsigned BIT_A = 7;
    localparam int unsigned BIT_E = 3;
    localparam int unsigned BIT_F = 2;
    localparam int unsigned BIT_G = 1;
    localparam int unsigned BIT_H = 0;
    localparam int unsigned SUB_LSB = 4;
    localparam logic [7:0] SPACE_CONST = 8'h20;
    localparam logic [7:0] CTRL_MASK = 8'h1F;
    localparam logic [2:0] SUB_0 = 3'h0;
    localparam logic [2:0] SUB_1 = 3'h1;
    localparam logic [2:0] SUB_2 = 3'h2;
    localparam logic [2:0] SUB_3 = 3'h3;
    localparam logic [2:0] SUB_4 = 3'h4;
    localparam logic [2:0] SUB_5 = 3'h5;
    localparam logic [2:0] SUB_6 = 3'h6;
    localparam logic [2:0] SUB_7 = 3'h7;
    // ram write source select
    localparam logic [1:0] SRC_WORK = 2'h0;
    localparam logic [1:0] SRC_RX = 2'h1;
    localparam logic [1:0] SRC_SPACE = 2'h2;
    localparam logic [1:0] SRC_CONST = 2'h3;
    // register offsets (OFF_*): byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PC = 8'h08;
    localparam logic [7:0] OFF_WORK = 8'h0C;
    localparam int unsigned CTRL_RUN = 0;
    typedef enum logic [2:0] {
        TMD_SLOT_TE = 3'b000,
        TMD_SLOT_TF = 3'b001,
        TMD_SLOT_TW = 3'b010,
        TMD_SLOT_TG = 3'b011,
        TMD_SLOT_TH = 3'b100,
        TMD_SLOT_TJ = 3'b101
    } tmd_slot_e;
endpackage

// ===== verif/testbench.sv
// self-checking testbench for the terminal microinstruction decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, control_key, ram_we;
    logic [7:0] paddr, rom_data, ram_rdata, rx_data, ram_wdata, wd_d;
    logic [7:0] te_strobe_n, tf_strobe_n, th_strobe_n, alt_strobe_n;
    logic [31:0] pwdata, prdata;
    logic [9:0] rom_addr, addr_d;
    logic [15:0] flags_n;
    logic [15:0] exp_q[$];
    logic [33:0] apb_q[$];
    logic [33:0] a_e;
    logic we_d, sel_o, done_o;
    logic [7:0] work_o;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    tmd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rom_data(rom_data), .rom_addr(rom_addr), .flags_n(flags_n),
        .ram_rdata(ram_rdata), .rx_data(rx_data), .column_val(6'h00),
        .control_key(control_key), .te_strobe_n(te_strobe_n), .tf_strobe_n(tf_strobe_n),
        .th_strobe_n(th_strobe_n), .alt_strobe_n(alt_strobe_n), .ram_we(ram_we),
        .ram_wdata(ram_wdata), .working_value_register(work_o), .select_flag_q(sel_o),
        .done_flag_q(done_o), .timing_slot(), .slot_pulse());
    tmd_rom_model u_rom (.pclk(pclk), .presetn(presetn), .rom_addr(rom_addr),
        .rom_data(rom_data), .ram_we(ram_we), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic ins(input logic [9:0] a, input logic [7:0] w);
        logic [7:0] v;
        v = ~(8'h01 << w[6:4]);
        u_rom.mem[a] = w;
        if (!w[7] && w[3]) exp_q.push_back({8'h00, v});
        if (!w[7] && w[2]) exp_q.push_back({8'h10, v});
        if (!w[7] && w[3:0] == 4'h0) exp_q.push_back({8'h30, v});
        // memory-inbound words of odd subsets have no outbound strobe
        if (!w[7] && w[1] && !w[4]) exp_q.push_back({8'h20, v});
    endtask
    task automatic nxt(input logic [9:0] a);
        exp_q.push_back({6'h14, a});
    endtask
    task automatic take(input logic [15:0] got);
        logic [15:0] e;
        total_checks++;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFFF;
        if (got !== e) begin
            fails++;
            $display("[FAIL] %0t event %h expected %h", $time, got, e);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        n = 0;
        apb_q.push_back({wr, e});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            print_verdict();
        end
    end
    always @(posedge pclk) begin
        if (!presetn) begin
            we_d <= 1'b0;
            addr_d <= 10'h000;
        end else begin
            if (te_strobe_n !== 8'hFF) take({8'h00, te_strobe_n});
            if (tf_strobe_n !== 8'hFF) take({8'h10, tf_strobe_n});
            if (th_strobe_n !== 8'hFF) take({8'h20, th_strobe_n});
            if (alt_strobe_n !== 8'hFF) take({8'h30, alt_strobe_n});
            if (we_d && !ram_we) take({8'h40, wd_d});
            if (rom_addr !== addr_d && exp_q.size() > 0) take({6'h14, rom_addr});
            we_d <= ram_we;
            wd_d <= ram_wdata;
            addr_d <= rom_addr;
        end
        if (psel && penable && pready === 1'b1) begin
            a_e = apb_q.pop_front();
            total_checks++;
            if (pslverr !== a_e[32] || (!a_e[33] && prdata !== a_e[31:0])) begin
                fails++;
                $display("[FAIL] %0t apb answer %h err %b", $time, prdata, pslverr);
            end
        end
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(32'hC482));
        flags_n = 16'($urandom);
        control_key = 1'($urandom);
        rx_data = 8'($urandom);
        @(posedge pclk);
        ins(0, 8'h48);
        nxt(1);
        ins(1, 8'h14);
        nxt(2);
        ins(2, 8'h16);
        exp_q.push_back(16'h4002);
        nxt(3);
        ins(3, 8'h32);
        exp_q.push_back(16'h4020);
        nxt(4);
        ins(4, 8'h00);
        nxt(5);
        ins(5, 8'h30);
        nxt(6);
        ins(6, 8'h83);
        exp_q.push_back(16'h4003);
        nxt(7);
        ins(7, 8'h11);
        nxt(8);
        u_rom.mem[8] = 8'h0C;
        ins(9, 8'h51);
        u_rom.mem[10] = 8'h0C;
        if (flags_n[1]) begin
            nxt(9);
            nxt(10);
        end
        nxt(10'h00C);
        ins(10'h00C, 8'h5C);
        nxt(10'h00D);
        ins(10'h00D, 8'h04);
        nxt(10'h00E);
        ins(10'h00E, 8'hE3);
        exp_q.push_back(control_key ? 16'h4003 : 16'h4063);
        nxt(10'h00F);
        ins(10'h00F, 8'h87);
        nxt(10'h010);
        ins(10'h010, 8'h71);
        nxt(10'h011);
        u_rom.mem[10'h011] = 8'h20;
        u_rom.mem[10'h012] = 8'h51;
        u_rom.mem[10'h013] = 8'h20;
        if (flags_n[15]) begin
            nxt(10'h012);
            nxt(10'h013);
        end
        nxt(10'h120);
        ins(10'h120, 8'h42);
        nxt(10'h121);
        u_rom.mem[10'h121] = 8'h51;
        u_rom.mem[10'h122] = 8'h21;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        while (exp_q.size() > 0) @(posedge pclk);
        total_checks++;
        if (sel_o !== 1'b1 || done_o !== 1'b0 || work_o !== 8'h04) begin
            fails++;
            $display("[FAIL] %0t mirrors %b %b %h", $time, sel_o, done_o, work_o);
        end
        apb(1'b1, tmd_pkg::OFF_CTRL, 32'h0, 33'h0);
        apb(1'b0, tmd_pkg::OFF_CTRL, 32'h0, 33'h0);
        apb(1'b0, tmd_pkg::OFF_WORK, 32'h0, {1'b0, 32'h4});
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h14, 32'hFFFF_FFFF, {1'b1, 32'h0});
        apb(1'b1, tmd_pkg::OFF_CTRL, 32'h1, 33'h0);
        repeat (4) @(posedge pclk);
        print_verdict();
    end
endmodule
`default_nettype wire

// ===== verif/tmd_decoder_assertions.sv
// checker: port-level assertions for the terminal microinstruction decoder
`timescale 1ns/1ps
`default_nettype none
module tmd_decoder_checker #(
    parameter int unsigned CYCLE_CYC = 130
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [9:0] rom_addr,
    input wire logic [7:0] te_strobe_n,
    input wire logic [7:0] tf_strobe_n,
    input wire logic [7:0] th_strobe_n,
    input wire logic [7:0] alt_strobe_n,
    input wire logic ram_we,
    input wire logic [7:0] ram_wdata
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_te_onehot: assert property ($onehot0(~te_strobe_n))
        else $error("te strobe drives several lines");
    chk_alt_onehot: assert property ($onehot0(~alt_strobe_n))
        else $error("alt strobe drives several lines");
    chk_strobe_single: assert property ((tf_strobe_n != 8'hFF) |=> tf_strobe_n == 8'hFF)
        else $error("tf strobe longer than one cycle");
    chk_te_before_tf: assert property ((te_strobe_n != 8'hFF)
        |=> (tf_strobe_n == 8'hFF && th_strobe_n == 8'hFF) [*8])
        else $error("strobe too close after te");
    chk_pc_quiet: assert property ($changed(rom_addr)
        |=> ($stable(rom_addr) && te_strobe_n == 8'hFF) [*8])
        else $error("pc or strobe moved right after fetch");
    chk_we_width: assert property ($rose(ram_we) |-> ram_we [*8] ##[1:10] !ram_we)
        else $error("ram write strobe width wrong");
    chk_wdata_hold: assert property (ram_we && $past(ram_we) |-> $stable(ram_wdata))
        else $error("ram write data moved during write");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_unmapped_err: assert property (psel && penable && pready && !pwrite && paddr > 8'h0C
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    cov_write: cover property ($rose(ram_we));
    cov_alt: cover property (alt_strobe_n != 8'hFF);
    cov_err: cover property (pready && pslverr);
endmodule
bind tmd_decoder tmd_decoder_checker #(.CYCLE_CYC(CYCLE_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
    .te_strobe_n(te_strobe_n), .tf_strobe_n(tf_strobe_n), .th_strobe_n(th_strobe_n),
    .alt_strobe_n(alt_strobe_n), .ram_we(ram_we), .ram_wdata(ram_wdata)
);
`default_nettype wire

// ===== verif/tmd_rom_model.sv
// partner model: microprogram rom and one ram cell
`timescale 1ns/1ps
`default_nettype none
module tmd_rom_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] rom_addr,
    output logic [7:0] rom_data,
    input wire logic ram_we,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata
);
    logic [7:0] mem [0:1023];
    logic [7:0] cell_q;
    // unloaded words read as the inverted low address byte, so values repeat only every 256 words
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = ~i[7:0];
        end
    end
    assign rom_data = mem[rom_addr];
    assign ram_rdata = cell_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_q <= 8'h00;
        end else if (ram_we) begin
            cell_q <= ram_wdata;
        end
    end
endmodule
`default_nettype wire
